// >>> verilog/dptb_pkg.sv
// Package for the digital I/O, PWM and trigger bus block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
package dptb_pkg;

	// Register byte offsets.
	localparam logic [7:0] DPTB_DIO_OUT_OFS  = 8'h00;
	localparam logic [7:0] DPTB_DIO_DIR_OFS  = 8'h04;
	localparam logic [7:0] DPTB_DIO_POL_OFS  = 8'h08;
	localparam logic [7:0] DPTB_DIO_IN_OFS   = 8'h0C;
	localparam logic [7:0] DPTB_PWM_CTL_OFS  = 8'h10;
	localparam logic [7:0] DPTB_PWM0_PER_OFS = 8'h14;
	localparam logic [7:0] DPTB_PWM0_DTY_OFS = 8'h18;
	localparam logic [7:0] DPTB_PULSE_OUT_FIRST_PER_OFS = 8'h1C;
	localparam logic [7:0] DPTB_PULSE_OUT_FIRST_DTY_OFS = 8'h20;
	localparam logic [7:0] DPTB_TB_MODE_OFS  = 8'h24;
	localparam logic [7:0] DPTB_TB_OUT_OFS   = 8'h28;
	localparam logic [7:0] DPTB_BP_POS_OFS   = 8'h2C;
	localparam logic [7:0] DPTB_STATUS_OFS   = 8'h30;

	// Field positions.
	localparam int DPTB_PWM_EXT_BIT   = 0;
	localparam int DPTB_ST_PULLUP_BIT = 0;
	localparam int DPTB_ST_STAR_BIT   = 1;
	localparam int DPTB_ST_BPLVL_BIT  = 2;
	localparam int DPTB_ST_TB_LSB     = 8;

	// Reset values.
	localparam logic [31:0] DPTB_ZERO_RST = 32'h0000_0000;

	// Trigger bus line modes, two bits per line.
	localparam logic [1:0] DPTB_TB_INPUT = 2'h0;
	localparam logic [1:0] DPTB_TB_GPIO  = 2'h1;
	localparam logic [1:0] DPTB_TB_BRKPT = 2'h2;
	localparam logic [1:0] DPTB_TB_ENCOD = 2'h3;

	// Timing.
	localparam int DPTB_CLK_HZ      = 125_000_000;
	localparam int DPTB_BP_PULSE_NS = 200;
	localparam int DPTB_BP_CYCLES   =
		(DPTB_BP_PULSE_NS * (DPTB_CLK_HZ / 1_000_000) + 999) / 1000;

	// One PWM channel setting.
	typedef struct packed {
		logic [15:0] period;
		logic [15:0] duty;
	} dptb_pwm_cfg_type;

	// Pin pair of a two-way line group.
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] oe;
	} dptb_tb_drv_type;

endpackage : dptb_pkg

// >>> verilog/dptb_top.sv
// Digital I/O ports, two PWM generators and trigger bus routing.
// Assumes one 125 MHz clock, Wishbone classic master, raw pins on inputs.
// Functional notes
// - Four eight-bit ports form 32 lines.
// - Ports written and read one byte each.
// - Per-line direction and polarity set by software.
// - Strap picks pull-up or pull-down at power-up.
// - Two PWMs, own period and duty.
// - High time proportional to commanded duty.
// - PWM counts internal clock or external pin.
// - Eight bus lines routed to triggers, breakpoints, encoders.
// - Bus lines usable as generic I/O port.
// - Star line is input only, never driven.
// - Breakpoint gives one 200 ns high pulse.
// - Encoder lines carry filtered signals, output only.
// - Trigger and generic inputs pass unaltered.
// - Breakpoint changes state on position match.
`timescale 1ns/1ps
module dptb_top
	import dptb_pkg::*;
#(
	parameter int FILT_LEN = 4
) (
	// Clock and reset.
	input  wire logic        clock_in,
	input  wire logic        resetn_in,
	// Wishbone classic slave.
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// Digital I/O lines and strap.
	input  wire logic [31:0] dio_in,
	output logic      [31:0] dio_out,
	output logic      [31:0] dio_oe_out,
	input  wire logic        pull_select_strap_in,
	output logic             dio_pull_up_out,
	// PWM.
	input  wire logic        pwm_clk_pin_in,
	output logic             pulse_out_first_out,
	output logic             pulse_out_second_out,
	// Trigger bus, encoder and position.
	input  wire logic [7:0]  tb_in,
	output logic      [7:0]  tb_out,
	output logic      [7:0]  tb_oe_out,
	input  wire logic        tb_star_in,
	output logic      [7:0]  tb_trig_out,
	output logic             star_trig_out,
	input  wire logic [2:0]  enc_raw_in,
	input  wire logic [31:0] enc_count_in,
	output logic             bp_level_out
);

	// Elaboration check: the filter run counter is only four bits wide.
	if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_bad_filt
		$error("FILT_LEN must be 2 to 16");
	end

	// Register file.
	logic [31:0] dio_out_q, dio_dir_q, dio_pol_q;
	logic        pwm_ext_q;
	dptb_pwm_cfg_type pwm_cfg_q [2];
	logic [15:0] tb_mode_q;
	logic [7:0]  tb_gpo_q;
	logic [31:0] bp_pos_q;
	logic        ack_q;
	logic [31:0] rdat_q;

	// Pin synchronisers, two flops each; the PWM clock pin has a third for edge detection.
	logic [31:0] dio_s1_q, dio_s2_q;
	logic [7:0]  tb_s1_q, tb_s2_q;
	logic        star_s1_q, star_s2_q;
	logic        pclk_s1_q, pclk_s2_q, pclk_s3_q;
	logic        strap_s1_q, strap_s2_q, strap_done_q;
	logic [2:0]  enc_s1_q, enc_s2_q;

	always_ff @(posedge clock_in) begin
		dio_s1_q   <= dio_in;
		dio_s2_q   <= dio_s1_q;
		tb_s1_q    <= tb_in;
		tb_s2_q    <= tb_s1_q;
		star_s1_q  <= tb_star_in;
		star_s2_q  <= star_s1_q;
		pclk_s1_q  <= pwm_clk_pin_in;
		pclk_s2_q  <= pclk_s1_q;
		pclk_s3_q  <= pclk_s2_q;
		strap_s1_q <= pull_select_strap_in;
		strap_s2_q <= strap_s1_q;
		enc_s1_q   <= enc_raw_in;
		enc_s2_q   <= enc_s1_q;
	end

	// Strap caught once after reset release; an open pin is pulled high
	// externally, so high or open both select pull-ups.
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			dio_pull_up_out <= 1'b1;
			strap_done_q    <= 1'b0;
		end else if (!strap_done_q) begin
			dio_pull_up_out <= strap_s2_q;
			strap_done_q    <= 1'b1;
		end
	end

	// Bus decode.
	logic wb_req, wb_wr;
	assign wb_req = wb_cyc_in && wb_stb_in && !ack_q;
	assign wb_wr  = wb_req && wb_we_in;

	// Byte lane merge, one byte per port.
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[8*b +: 8] = new_v[8*b +: 8];
		return r;
	endfunction : lane_merge

	// Port, direction and polarity registers.
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			dio_out_q <= DPTB_ZERO_RST;
			dio_dir_q <= DPTB_ZERO_RST;
			dio_pol_q <= DPTB_ZERO_RST;
		end else if (wb_wr) begin
			case (wb_adr_in)
				DPTB_DIO_OUT_OFS: dio_out_q <=
					lane_merge(dio_out_q, wb_dat_in, wb_sel_in);
				DPTB_DIO_DIR_OFS: dio_dir_q <=
					lane_merge(dio_dir_q, wb_dat_in, wb_sel_in);
				DPTB_DIO_POL_OFS: dio_pol_q <=
					lane_merge(dio_pol_q, wb_dat_in, wb_sel_in);
				default: ;
			endcase
		end
	end

	// PWM and routing registers.
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			pwm_ext_q    <= 1'b0;
			pwm_cfg_q[0] <= DPTB_ZERO_RST;
			pwm_cfg_q[1] <= DPTB_ZERO_RST;
			tb_mode_q    <= DPTB_ZERO_RST[15:0];
			tb_gpo_q     <= DPTB_ZERO_RST[7:0];
			bp_pos_q     <= DPTB_ZERO_RST;
		end else if (wb_wr) begin
			case (wb_adr_in)
				DPTB_PWM_CTL_OFS:  pwm_ext_q <= wb_dat_in[DPTB_PWM_EXT_BIT];
				DPTB_PWM0_PER_OFS: pwm_cfg_q[0].period <= wb_dat_in[15:0];
				DPTB_PWM0_DTY_OFS: pwm_cfg_q[0].duty   <= wb_dat_in[15:0];
				DPTB_PULSE_OUT_FIRST_PER_OFS: pwm_cfg_q[1].period <= wb_dat_in[15:0];
				DPTB_PULSE_OUT_FIRST_DTY_OFS: pwm_cfg_q[1].duty   <= wb_dat_in[15:0];
				DPTB_TB_MODE_OFS:  tb_mode_q <= wb_dat_in[15:0];
				DPTB_TB_OUT_OFS:   tb_gpo_q  <= wb_dat_in[7:0];
				DPTB_BP_POS_OFS:   bp_pos_q  <= wb_dat_in;
				default: ;
			endcase
		end
	end

	// Read mux; ack comes one cycle after the request, unmapped reads zero.
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			ack_q  <= 1'b0;
			rdat_q <= DPTB_ZERO_RST;
		end else begin
			ack_q <= wb_req;
			if (wb_req) begin
				case (wb_adr_in)
					DPTB_DIO_OUT_OFS:  rdat_q <= dio_out_q;
					DPTB_DIO_DIR_OFS:  rdat_q <= dio_dir_q;
					DPTB_DIO_POL_OFS:  rdat_q <= dio_pol_q;
					DPTB_DIO_IN_OFS:   rdat_q <= dio_s2_q ^ dio_pol_q;
					DPTB_PWM_CTL_OFS:  rdat_q <= {31'h0, pwm_ext_q};
					DPTB_PWM0_PER_OFS: rdat_q <= {16'h0, pwm_cfg_q[0].period};
					DPTB_PWM0_DTY_OFS: rdat_q <= {16'h0, pwm_cfg_q[0].duty};
					DPTB_PULSE_OUT_FIRST_PER_OFS: rdat_q <= {16'h0, pwm_cfg_q[1].period};
					DPTB_PULSE_OUT_FIRST_DTY_OFS: rdat_q <= {16'h0, pwm_cfg_q[1].duty};
					DPTB_TB_MODE_OFS:  rdat_q <= {16'h0, tb_mode_q};
					DPTB_TB_OUT_OFS:   rdat_q <= {24'h0, tb_gpo_q};
					DPTB_BP_POS_OFS:   rdat_q <= bp_pos_q;
					DPTB_STATUS_OFS: begin
						rdat_q <= DPTB_ZERO_RST;
						rdat_q[DPTB_ST_PULLUP_BIT] <= dio_pull_up_out;
						rdat_q[DPTB_ST_STAR_BIT]   <= star_s2_q;
						rdat_q[DPTB_ST_BPLVL_BIT]  <= bp_level_out;
						rdat_q[DPTB_ST_TB_LSB +: 8] <= tb_s2_q;
					end
					default: rdat_q <= DPTB_ZERO_RST;
				endcase
			end
		end
	end
	assign wb_ack_out = ack_q;
	assign wb_dat_out = rdat_q;

	// Digital line drivers; polarity inverts both directions.
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			dio_out    <= DPTB_ZERO_RST;
			dio_oe_out <= DPTB_ZERO_RST;
		end else begin
			dio_out    <= dio_out_q ^ dio_pol_q;
			dio_oe_out <= dio_dir_q;
		end
	end

	// PWM tick: every cycle, or the synced rising edge of the external pin.
	logic pwm_tick;
	assign pwm_tick = pwm_ext_q ? (pclk_s2_q && !pclk_s3_q) : 1'b1;

	// Two generators; a zero period keeps the output low.
	logic [15:0] pwm_cnt_q [2];
	logic [1:0]  pwm_lvl_q;
	for (genvar c = 0; c < 2; c++) begin : g_pwm
		always_ff @(posedge clock_in) begin
			if (!resetn_in) begin
				pwm_cnt_q[c] <= DPTB_ZERO_RST[15:0];
				pwm_lvl_q[c] <= 1'b0;
			end else if (pwm_cfg_q[c].period == 16'h0000) begin
				pwm_cnt_q[c] <= DPTB_ZERO_RST[15:0];
				pwm_lvl_q[c] <= 1'b0;
			end else if (pwm_tick) begin
				// Period and duty per channel are independent.
				if (pwm_cnt_q[c] >= pwm_cfg_q[c].period - 16'h0001)
					pwm_cnt_q[c] <= DPTB_ZERO_RST[15:0];
				else
					pwm_cnt_q[c] <= pwm_cnt_q[c] + 16'h0001;
				pwm_lvl_q[c] <= pwm_cnt_q[c] < pwm_cfg_q[c].duty;
			end
		end
	end
	assign pulse_out_first_out  = pwm_lvl_q[0];
	assign pulse_out_second_out = pwm_lvl_q[1];

	// Encoder filter: a signal changes only after FILT_LEN equal samples,
	// trading a few cycles of delay for immunity to short glitches.
	logic [2:0] enc_filt_q;
	logic [3:0] enc_run_q [3];
	for (genvar e = 0; e < 3; e++) begin : g_filt
		always_ff @(posedge clock_in) begin
			if (!resetn_in) begin
				enc_filt_q[e] <= 1'b0;
				enc_run_q[e]  <= 4'h0;
			end else if (enc_s2_q[e] == enc_filt_q[e]) begin
				enc_run_q[e]  <= 4'h0;
			end else if (enc_run_q[e] == 4'(FILT_LEN - 1)) begin
				enc_filt_q[e] <= enc_s2_q[e];
				enc_run_q[e]  <= 4'h0;
			end else begin
				enc_run_q[e]  <= enc_run_q[e] + 4'h1;
			end
		end
	end

	// Breakpoint: level toggles on the first cycle of a match and a
	// fixed-width pulse is timed from the system clock.
	localparam logic [7:0] BP_LEN = 8'(DPTB_BP_CYCLES);
	logic       bp_hit_q, bp_pulse_q;
	logic [7:0] bp_cnt_q;
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			bp_hit_q     <= 1'b0;
			bp_level_out <= 1'b0;
			bp_pulse_q   <= 1'b0;
			bp_cnt_q     <= 8'h00;
		end else begin
			bp_hit_q <= enc_count_in == bp_pos_q;
			if (enc_count_in == bp_pos_q && !bp_hit_q) begin
				bp_level_out <= !bp_level_out;
				bp_pulse_q   <= 1'b1;
				bp_cnt_q     <= BP_LEN - 8'h01;
			end else if (bp_cnt_q != 8'h00) begin
				bp_cnt_q <= bp_cnt_q - 8'h01;
			end else begin
				bp_pulse_q <= 1'b0;
			end
		end
	end

	// Trigger bus lines: drive per mode, pass inputs through untouched.
	dptb_tb_drv_type tb_drv_q;
	for (genvar l = 0; l < 8; l++) begin : g_tb
		logic [1:0] mode;
		assign mode = tb_mode_q[2*l +: 2];
		always_ff @(posedge clock_in) begin
			if (!resetn_in) begin
				tb_drv_q.data[l] <= 1'b0;
				tb_drv_q.oe[l]   <= 1'b0;
				tb_trig_out[l]   <= 1'b0;
			end else begin
				tb_trig_out[l] <= tb_s2_q[l];
				case (mode)
					DPTB_TB_INPUT: begin
						tb_drv_q.data[l] <= 1'b0;
						tb_drv_q.oe[l]   <= 1'b0;
					end
					DPTB_TB_GPIO: begin
						tb_drv_q.data[l] <= tb_gpo_q[l];
						tb_drv_q.oe[l]   <= 1'b1;
					end
					DPTB_TB_BRKPT: begin
						tb_drv_q.data[l] <= bp_pulse_q;
						tb_drv_q.oe[l]   <= 1'b1;
					end
					DPTB_TB_ENCOD: begin
						tb_drv_q.data[l] <= enc_filt_q[l % 3];
						tb_drv_q.oe[l]   <= 1'b1;
					end
					default: begin
						tb_drv_q.data[l] <= 1'b0;
						tb_drv_q.oe[l]   <= 1'b0;
					end
				endcase
			end
		end
	end
	assign tb_out    = tb_drv_q.data;
	assign tb_oe_out = tb_drv_q.oe;

	// Star line has no driver at all; it only feeds a trigger and a status bit.
	always_ff @(posedge clock_in) begin
		if (!resetn_in)
			star_trig_out <= 1'b0;
		else
			star_trig_out <= star_s2_q;
	end

endmodule : dptb_top

// >>> bench/dptb_far.sv
// Far-side model: external DIO wiring and other trigger bus instruments.
// Assumes the bench sets what the other instruments drive on the bus.
`timescale 1ns/1ps
module dptb_far (
	// Device pins.
	input  wire logic [31:0] dio_out,
	input  wire logic [31:0] dio_oe_out,
	input  wire logic        dio_pull_up_out,
	input  wire logic [7:0]  tb_out,
	input  wire logic [7:0]  tb_oe_out,
	// Drive from the other instruments.
	input  wire logic [7:0]  ext_tb_in,
	// Resolved line levels.
	output logic      [31:0] pin_dio_out,
	output logic      [7:0]  pin_tb_out
);
	// A released DIO line settles at the pull level that the strap set.
	assign pin_dio_out = (dio_out & dio_oe_out)
		| (~dio_oe_out & {32{dio_pull_up_out}});
	// The device wins any line it drives; the rest follow the others.
	assign pin_tb_out = (tb_out & tb_oe_out)
		| (~tb_oe_out & ext_tb_in);
endmodule : dptb_far

// >>> bench/dptb_top_asserts.sv
// Checker for bus handshake, pin stability and pass-through paths.
// Assumes binding onto dptb_top; it sees the top module's ports only.
`timescale 1ns/1ps
module dptb_chk (
	// Clock, reset and bus.
	input wire logic        clock_in,
	input wire logic        resetn_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic        wb_ack_out,
	// Pins.
	input wire logic [31:0] dio_out,
	input wire logic [31:0] dio_oe_out,
	input wire logic        dio_pull_up_out,
	input wire logic        pulse_out_first_out,
	input wire logic        pulse_out_second_out,
	input wire logic [7:0]  tb_in,
	input wire logic [7:0]  tb_trig_out,
	input wire logic        tb_star_in,
	input wire logic        star_trig_out
);
	logic       take;
	logic [1:0] up_q;
	logic       wr_q;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	// A request that the slave takes at this edge.
	assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
	// Edges since reset; the input pipes need three to fill.
	always_ff @(posedge clock_in) begin
		if (!resetn_in) up_q <= 2'h0;
		else if (up_q != 2'h3) up_q <= up_q + 2'h1;
	end
	// Set by the first write, since PWM must idle until programmed.
	always_ff @(posedge clock_in) begin
		if (!resetn_in) wr_q <= 1'b0;
		else if (take && wb_we_in) wr_q <= 1'b1;
	end
	property p_ack; take |=> wb_ack_out; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_one; wb_ack_out |=> !wb_ack_out; endproperty
	a_one: assert property (p_one) else $error("ack too long");
	property p_idle; !wr_q |-> !pulse_out_first_out && !pulse_out_second_out;
	endproperty
	a_idle: assert property (p_idle) else $error("pwm early");
	property p_dout; !$past(take) && !$past(take, 2) |-> $stable(dio_out);
	endproperty
	a_dout: assert property (p_dout) else $error("dio moved");
	property p_doe; !$past(take) && !$past(take, 2) |-> $stable(dio_oe_out);
	endproperty
	a_doe: assert property (p_doe) else $error("dir moved");
	property p_pull; up_q == 2'h3 |-> $stable(dio_pull_up_out); endproperty
	a_pull: assert property (p_pull) else $error("pull moved");
	property p_trig; up_q == 2'h3 |-> tb_trig_out == $past(tb_in, 3);
	endproperty
	a_trig: assert property (p_trig) else $error("trig bad");
	property p_star; up_q == 2'h3 |-> star_trig_out == $past(tb_star_in, 3);
	endproperty
	a_star: assert property (p_star) else $error("star bad");
endmodule : dptb_chk
bind dptb_top dptb_chk u_chk (.clock_in, .resetn_in, .wb_cyc_in,
	.wb_stb_in, .wb_we_in, .wb_ack_out, .dio_out, .dio_oe_out,
	.dio_pull_up_out, .pulse_out_first_out, .pulse_out_second_out,
	.tb_in, .tb_trig_out, .tb_star_in, .star_trig_out);

// >>> bench/dptb_top_bench.sv
// Bench for dptb_top: Wishbone tasks and directed checks.
// Assumes the far-side model closes the DIO and trigger bus loops.
`timescale 1ns/1ps
module dptb_top_bench;
	import dptb_pkg::*;
	logic        clock_in, resetn_in, wb_cyc_in, wb_stb_in, wb_we_in;
	logic        wb_ack_out, pull_select_strap_in, dio_pull_up_out;
	logic        pwm_clk_pin_in, pulse_out_first_out, pulse_out_second_out;
	logic        tb_star_in, star_trig_out, bp_level_out;
	logic [2:0]  enc_raw_in;
	logic [3:0]  wb_sel_in;
	logic [7:0]  wb_adr_in, tb_in, tb_out, tb_oe_out, tb_trig_out, ext_tb;
	logic [31:0] wb_dat_in, wb_dat_out, dio_in, dio_out, dio_oe_out;
	logic [31:0] enc_count_in, q;
	int          h;
	int          mismatches = 0;
	int          cmp_count = 0;
	dptb_top #(.FILT_LEN(4)) uut (.clock_in, .resetn_in, .wb_cyc_in,
		.wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
		.wb_dat_out, .wb_ack_out, .dio_in, .dio_out, .dio_oe_out,
		.pull_select_strap_in, .dio_pull_up_out, .pwm_clk_pin_in,
		.pulse_out_first_out, .pulse_out_second_out, .tb_in, .tb_out,
		.tb_oe_out, .tb_star_in, .tb_trig_out, .star_trig_out,
		.enc_raw_in, .enc_count_in, .bp_level_out);
	dptb_far u_far (.dio_out, .dio_oe_out, .dio_pull_up_out, .tb_out,
		.tb_oe_out, .ext_tb_in(ext_tb), .pin_dio_out(dio_in),
		.pin_tb_out(tb_in));
	// 125 MHz system clock.
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One classic cycle; held until ack, then dropped for a cycle.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		{wb_cyc_in, wb_stb_in, wb_we_in} <= {2'h3, w};
		{wb_adr_in, wb_sel_in, wb_dat_in} <= {a, s, d};
		// No cycle count is assumed; only the watchdog ends a hung wait.
		do begin
			@(posedge clock_in);
		end while (wb_ack_out !== 1'b1);
		q = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'h0;
		@(posedge clock_in);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		bus(1'b1, a, d, s);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(q, e);
	endtask : rd
	// Counts PWM highs over 40 ticks after 8 ticks to settle the lag.
	task automatic meas(input logic x, input int e0, input int e1);
		int h0;
		int h1;
		h0 = 0;
		h1 = 0;
		for (int i = 0; i < 48; i++) begin
			if (x) begin
				pwm_clk_pin_in <= 1'b1;
				repeat (2) @(posedge clock_in);
				pwm_clk_pin_in <= 1'b0;
				repeat (2) @(posedge clock_in);
			end else begin
				@(posedge clock_in);
			end
			if (i >= 8) h0 += int'(pulse_out_first_out === 1'b1);
			if (i >= 8) h1 += int'(pulse_out_second_out === 1'b1);
		end
		chk(32'(h0), 32'(e0));
		chk(32'(h1), 32'(e1));
	endtask : meas
	// Whole run is about 500 cycles; sixty times that is a hang.
	initial begin
		#240000;
		mismatches++;
		print_verdict();
	end
	// Main sequence.
	initial begin
		{resetn_in, wb_cyc_in, wb_stb_in, wb_we_in} = 4'h0;
		{wb_adr_in, wb_sel_in, wb_dat_in} = 44'h0;
		{pwm_clk_pin_in, tb_star_in, enc_raw_in, ext_tb} = 13'h0;
		pull_select_strap_in = 1'b1;
		enc_count_in = 32'h8000_0000;
		repeat (16) @(posedge clock_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		chk(32'({pulse_out_first_out, pulse_out_second_out}), 32'h0);
		rd(DPTB_STATUS_OFS, 32'h1);
		rd(DPTB_PWM_CTL_OFS, 32'h0);
		wr(DPTB_DIO_DIR_OFS, 32'hFF00FFFF, 4'hF);
		wr(DPTB_DIO_OUT_OFS, 32'h12345678, 4'h5);
		wr(DPTB_DIO_POL_OFS, 32'h0F0F0F0F, 4'hF);
		repeat (4) @(posedge clock_in);
		chk(dio_out, 32'h0F3B0F77);
		chk(dio_oe_out, 32'hFF00FFFF);
		rd(DPTB_DIO_IN_OFS, 32'h00F00078);
		wr(DPTB_PWM0_PER_OFS, 32'hA, 4'hF);
		wr(DPTB_PWM0_DTY_OFS, 32'h3, 4'hF);
		wr(DPTB_PULSE_OUT_FIRST_PER_OFS, 32'h8, 4'hF);
		wr(DPTB_PULSE_OUT_FIRST_DTY_OFS, 32'h6, 4'hF);
		meas(1'b0, 32'hC, 32'h1E);
		wr(DPTB_PWM_CTL_OFS, 32'h1, 4'hF);
		meas(1'b1, 32'hC, 32'h1E);
		ext_tb <= 8'h5A;
		tb_star_in <= 1'b1;
		repeat (5) @(posedge clock_in);
		chk(32'({tb_oe_out, tb_trig_out}), 32'h5A);
		rd(DPTB_STATUS_OFS, 32'h5A03);
		wr(DPTB_TB_MODE_OFS, 32'h5555, 4'hF);
		wr(DPTB_TB_OUT_OFS, 32'hC3, 4'hF);
		repeat (5) @(posedge clock_in);
		chk({tb_oe_out, tb_out, tb_trig_out, 8'h0}, 32'hFFC3C300);
		wr(DPTB_TB_MODE_OFS, 32'h2, 4'hF);
		wr(DPTB_BP_POS_OFS, 32'h100, 4'hF);
		// Two events: leave the position and return each time.
		for (int k = 0; k < 2; k++) begin
			enc_count_in <= 32'hFF;
			repeat (2) @(posedge clock_in);
			enc_count_in <= 32'h100;
			h = 0;
			repeat (60) begin
				@(posedge clock_in);
				h += int'(tb_out[0] === 1'b1 && tb_oe_out[0] === 1'b1);
			end
			chk(32'(h), 32'(DPTB_BP_CYCLES));
			chk(32'(bp_level_out), 32'(k == 0));
		end
		wr(DPTB_TB_MODE_OFS, 32'h3, 4'hF);
		enc_raw_in <= 3'h1;
		repeat (2) @(posedge clock_in);
		enc_raw_in <= 3'h0;
		repeat (10) @(posedge clock_in);
		chk(32'({tb_oe_out[0], tb_out[0]}), 32'h2);
		enc_raw_in <= 3'h1;
		repeat (12) @(posedge clock_in);
		chk(32'({tb_oe_out[0], tb_out[0]}), 32'h3);
		// Second reset with the strap tied low selects pull-downs.
		pull_select_strap_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		resetn_in <= 1'b0;
		repeat (16) @(posedge clock_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		rd(DPTB_STATUS_OFS, 32'h5A02);
		rd(DPTB_DIO_IN_OFS, 32'h0);
		rd(DPTB_PWM_CTL_OFS, 32'h0);
		rd(8'h3C, 32'h0);
		print_verdict();
	end
endmodule : dptb_top_bench
